// ### design/pgs_pkg.sv
// Shared constants and types of the priority group selector.
package pgs_pkg;

    // Group count and register port widths.
    localparam int N_GROUPS = 8;
    localparam int ADDR_W   = 4;
    localparam int DATA_W   = 32;
    localparam int SEL_W    = 4;
    localparam int GRP_W    = 3;

    // Register offsets on the plain register port.
    localparam logic [ADDR_W-1:0] OFF_CTRL   = 4'h0;
    localparam logic [ADDR_W-1:0] OFF_REMOTE = 4'h1;
    localparam logic [ADDR_W-1:0] OFF_LOCAL  = 4'h2;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 4'h3;

    // Control register fields.
    localparam int CTRL_FRC_EN_POS  = 0;
    localparam int CTRL_FRC_SEL_POS = 4;
    localparam int CTRL_USED_POS    = 8;

    // Remote and local registers hold a group selector in their low nibble.
    localparam int SEL_POS = 0;

    // Status register fields.
    localparam int STAT_ACT_POS    = 0;
    localparam int STAT_STATIC_POS = 8;
    localparam int STAT_REQ_POS    = 16;

    // Reset values.
    localparam logic             RST_FRC_EN  = 1'b0;
    localparam logic [SEL_W-1:0] RST_SEL     = 4'h0;
    localparam logic [GRP_W-1:0] RST_USED    = 3'h0;
    localparam logic [GRP_W-1:0] RST_ACTIVE  = 3'h0;

    // A selector value of zero means no group; one to eight name a group.
    localparam logic [SEL_W-1:0] SEL_NONE = 4'h0;
    localparam logic [SEL_W-1:0] SEL_MAX  = 4'h8;

    // A request held this long counts as a static level rather than a pulse.
    localparam int CLK_PERIOD_NS   = 20;
    localparam int STATIC_HOLD_NS  = 1000;
    localparam int STATIC_HOLD_CYC = (STATIC_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Event levels; each field yields an ON and an OFF pulse on change.
    typedef struct packed {
        logic [N_GROUPS-1:0] req;
        logic [N_GROUPS-1:0] act;
        logic [N_GROUPS-2:0] en;
        logic                remote_chg;
        logic                local_chg;
        logic                force_chg;
        logic                fail_cfg;
        logic                fail_force;
        logic                fail_prio;
    } pgs_lvl_t;

endpackage : pgs_pkg

// ### design/pgs_req_filter.sv
// Request input conditioner: rising edges and static-level detection per group.
`timescale 1ns/100ps
module pgs_req_filter #(
    parameter int N        = 8,
    parameter int HOLD_CYC = 50
) (
    input  wire logic         i_clk_sys,
    input  wire logic         i_rst,
    input  wire logic [N-1:0] i_req,
    output logic      [N-1:0] o_rise,
    output logic      [N-1:0] o_static
);
    localparam int CNT_W = $clog2(HOLD_CYC + 1);
    localparam logic [CNT_W-1:0] CNT_TOP = CNT_W'(HOLD_CYC);

    if (HOLD_CYC < 1) begin : g_bad_hold
        $error("pgs_req_filter: HOLD_CYC must be at least one");
    end

    logic [N-1:0] prev_ff;

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            prev_ff <= '0;
        end else begin
            prev_ff <= i_req;
        end
    end

    assign o_rise = i_req & ~prev_ff;

    for (genvar g = 0; g < N; g++) begin : g_bit
        logic [CNT_W-1:0] cnt_ff;
        logic [CNT_W-1:0] nxt_cnt;

        // The count saturates so a long-held level stays static indefinitely.
        assign nxt_cnt = !i_req[g] ? '0 : (cnt_ff == CNT_TOP) ? cnt_ff : cnt_ff + 1'b1;

        always_ff @(posedge i_clk_sys or posedge i_rst) begin
            if (i_rst) begin
                cnt_ff <= '0;
            end else begin
                cnt_ff <= nxt_cnt;
            end
        end

        assign o_static[g] = i_req[g] && (cnt_ff == CNT_TOP);
    end
endmodule : pgs_req_filter

// ### design/pgs_edge_events.sv
// Turns a vector of levels into registered one-cycle ON and OFF pulses.
`timescale 1ns/100ps
module pgs_edge_events #(
    parameter int         W    = 8,
    parameter logic [W-1:0] INIT = '0
) (
    input  wire logic         i_clk_sys,
    input  wire logic         i_rst,
    input  wire logic [W-1:0] i_lvl,
    output logic      [W-1:0] o_on,
    output logic      [W-1:0] o_off
);
    logic [W-1:0] prev_ff;
    logic [W-1:0] on_ff;
    logic [W-1:0] off_ff;

    // Starting from the reset image keeps reset itself from producing events.
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            prev_ff <= INIT;
            on_ff   <= '0;
            off_ff  <= '0;
        end else begin
            prev_ff <= i_lvl;
            on_ff   <= i_lvl & ~prev_ff;
            off_ff  <= ~i_lvl & prev_ff;
        end
    end

    assign o_on  = on_ff;
    assign o_off = off_ff;
endmodule : pgs_edge_events

// ### design/pgs_top.sv
// Priority group selector: picks one of eight parameter groups and reports events.
//
// Behaviour
// - Requests accepted as pulses or static levels.
// - Group one highest, group eight lowest priority.
// - Static group two-four blocks all lower requests.
// - Static group five blocks groups six to eight.
// - Static group seven blocks only group eight.
// - Static group eight suppresses nothing.
// - Group one returns only when requested again.
// - Events for control, requests, enables, failures.
// - Remote change request gives ON/OFF events.
// - Local change request gives ON/OFF events.
// - Unconfigured group request refused with failure events.
// - Request blocked by static higher raises failure.
// - Unhonourable forced request raises force failure.
// - Pulse-selected group stays until another request.
// - Static group one blocks every other request.
// - Forcing overrides inputs until forcing disabled.
// - Remote change loses to higher driven input.
//
// The implementer's own choices: the register addresses and the plain strobed port.
`timescale 1ns/100ps
module pgs_top #(
    parameter int N_GROUPS = pgs_pkg::N_GROUPS,
    parameter int HOLD_CYC = pgs_pkg::STATIC_HOLD_CYC
) (
    input  wire logic                            i_clk_sys,
    input  wire logic                            i_rst,
    input  wire logic [N_GROUPS-1:0]             i_group_request,
    input  wire logic [pgs_pkg::ADDR_W-1:0]      i_addr,
    input  wire logic [pgs_pkg::DATA_W-1:0]      i_wdata,
    input  wire logic                            i_wr,
    input  wire logic                            i_rd,
    output logic      [pgs_pkg::DATA_W-1:0]      o_rdata,
    output logic      [pgs_pkg::GRP_W-1:0]       o_active_group,
    output pgs_pkg::pgs_lvl_t                    o_events_on,
    output pgs_pkg::pgs_lvl_t                    o_events_off
);
    localparam int GW = pgs_pkg::GRP_W;
    localparam int SW = pgs_pkg::SEL_W;
    localparam int EW = $bits(pgs_pkg::pgs_lvl_t);

    // The event record and the group encodings are sized for exactly eight groups.
    if (N_GROUPS != pgs_pkg::N_GROUPS) begin : g_bad_groups
        $error("pgs_top: N_GROUPS must equal the package group count");
    end

    // Lowest set index wins; index zero is group one.
    function automatic logic [GW-1:0] pick_first(input logic [N_GROUPS-1:0] v);
        logic [GW-1:0] r;
        r = '0;
        for (int k = N_GROUPS - 1; k >= 0; k--) begin
            if (v[k]) begin
                r = GW'(k);
            end
        end
        return r;
    endfunction : pick_first

    // Mask of all groups of higher priority than the given index.
    function automatic logic [N_GROUPS-1:0] higher_mask(input logic [GW-1:0] idx);
        logic [N_GROUPS-1:0] m;
        m = '0;
        for (int k = 0; k < N_GROUPS; k++) begin
            m[k] = (GW'(k) < idx);
        end
        return m;
    endfunction : higher_mask

    // Register state.
    logic            frc_en_ff;
    logic [SW-1:0]   frc_sel_ff;
    logic [GW-1:0]   used_ff;
    logic [SW-1:0]   remote_sel_ff;
    logic [SW-1:0]   local_sel_ff;
    logic [GW-1:0]   active_ff;
    logic [GW-1:0]   nxt_active;
    logic [pgs_pkg::DATA_W-1:0] rdata_ff;
    logic [pgs_pkg::DATA_W-1:0] nxt_rdata;

    // Register decode.
    wire wr_ctrl   = i_wr && (i_addr == pgs_pkg::OFF_CTRL);
    wire wr_remote = i_wr && (i_addr == pgs_pkg::OFF_REMOTE);
    wire wr_local  = i_wr && (i_addr == pgs_pkg::OFF_LOCAL);
    wire [SW-1:0] wsel = i_wdata[pgs_pkg::SEL_POS +: SW];

    // Request conditioning.
    logic [N_GROUPS-1:0] req_rise;
    logic [N_GROUPS-1:0] req_static;

    pgs_req_filter #(
        .N        (N_GROUPS),
        .HOLD_CYC (HOLD_CYC)
    ) u_filter (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_req     (i_group_request),
        .o_rise    (req_rise),
        .o_static  (req_static)
    );

    // Configured groups: group one always, then up to the used-groups setting.
    logic [N_GROUPS-1:0] used_mask;
    // Groups blocked by a static level on some higher-priority group.
    logic [N_GROUPS-1:0] suppressed;

    for (genvar g = 0; g < N_GROUPS; g++) begin : g_grp
        assign used_mask[g] = (GW'(g) <= used_ff);
        if (g == 0) begin : g_first
            assign suppressed[g] = 1'b0;
        end else begin : g_rest
            // A static level masks every lower group only; group eight has none below.
            assign suppressed[g] = suppressed[g-1] | req_static[g-1];
        end
    end

    // A pulse selects once on its edge, a static level keeps asserting its group.
    wire [N_GROUPS-1:0] req_live = req_rise | req_static;
    wire [N_GROUPS-1:0] cand     = req_live & ~suppressed & used_mask;
    wire                cand_any = |cand;
    wire [GW-1:0]       cand_grp = pick_first(cand);

    // Forcing.
    wire          frc_sel_ok = (frc_sel_ff != pgs_pkg::SEL_NONE) &&
                               (frc_sel_ff <= pgs_pkg::SEL_MAX);
    wire [GW-1:0] frc_grp    = GW'(frc_sel_ff - 1'b1);
    wire          frc_apply  = frc_en_ff && frc_sel_ok && used_mask[frc_grp];
    wire          frc_fail   = frc_en_ff && (frc_sel_ff != pgs_pkg::SEL_NONE) && !frc_apply;

    // Remote and local change commands act on the write that names a group.
    wire          rem_sel_ok = (wsel != pgs_pkg::SEL_NONE) && (wsel <= pgs_pkg::SEL_MAX);
    wire [GW-1:0] cmd_grp    = GW'(wsel - 1'b1);
    // A higher group driven by any input level wins over a command.
    wire          cmd_blocked = |(i_group_request & higher_mask(cmd_grp));
    wire          cmd_ok      = rem_sel_ok && used_mask[cmd_grp] && !cmd_blocked;
    wire          rem_go      = wr_remote && cmd_ok;
    wire          loc_go      = wr_local && cmd_ok;

    // Pending command state, used for failure levels while the command stands.
    wire          rem_pend   = (remote_sel_ff != pgs_pkg::SEL_NONE);
    wire [GW-1:0] rem_grp    = GW'(remote_sel_ff - 1'b1);
    wire          rem_range  = (remote_sel_ff <= pgs_pkg::SEL_MAX);
    wire          loc_pend   = (local_sel_ff != pgs_pkg::SEL_NONE);
    wire [GW-1:0] loc_grp    = GW'(local_sel_ff - 1'b1);
    wire          loc_range  = (local_sel_ff <= pgs_pkg::SEL_MAX);

    wire rem_nocfg = rem_pend && (!rem_range || !used_mask[rem_grp]);
    wire loc_nocfg = loc_pend && (!loc_range || !used_mask[loc_grp]);
    wire rem_prio  = rem_pend && rem_range &&
                     |(i_group_request & higher_mask(rem_grp));
    wire loc_prio  = loc_pend && loc_range &&
                     |(i_group_request & higher_mask(loc_grp));

    // Failure levels; each edge of them becomes an ON or an OFF event.
    wire fail_cfg  = |(i_group_request & ~used_mask) | rem_nocfg | loc_nocfg;
    wire fail_prio = |(i_group_request & suppressed & used_mask) |
                     rem_prio | loc_prio;

    // Active group selection. Nothing falls back to group one by itself.
    always_comb begin
        nxt_active = active_ff;
        if (frc_apply) begin
            nxt_active = frc_grp;
        end else if (frc_en_ff) begin
            nxt_active = active_ff;
        end else if (cand_any) begin
            nxt_active = cand_grp;
        end else if (rem_go || loc_go) begin
            nxt_active = cmd_grp;
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            active_ff <= pgs_pkg::RST_ACTIVE;
        end else begin
            active_ff <= nxt_active;
        end
    end

    // Register writes.
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            frc_en_ff  <= pgs_pkg::RST_FRC_EN;
            frc_sel_ff <= pgs_pkg::RST_SEL;
            used_ff    <= pgs_pkg::RST_USED;
        end else if (wr_ctrl) begin
            frc_en_ff  <= i_wdata[pgs_pkg::CTRL_FRC_EN_POS];
            frc_sel_ff <= i_wdata[pgs_pkg::CTRL_FRC_SEL_POS +: SW];
            used_ff    <= i_wdata[pgs_pkg::CTRL_USED_POS +: GW];
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            remote_sel_ff <= pgs_pkg::RST_SEL;
            local_sel_ff  <= pgs_pkg::RST_SEL;
        end else begin
            if (wr_remote) begin
                remote_sel_ff <= wsel;
            end
            if (wr_local) begin
                local_sel_ff <= wsel;
            end
        end
    end

    // Read path: data stands only in the cycle after the read strobe.
    logic [pgs_pkg::DATA_W-1:0] ctrl_img;
    logic [pgs_pkg::DATA_W-1:0] stat_img;

    always_comb begin
        ctrl_img = '0;
        ctrl_img[pgs_pkg::CTRL_FRC_EN_POS]        = frc_en_ff;
        ctrl_img[pgs_pkg::CTRL_FRC_SEL_POS +: SW] = frc_sel_ff;
        ctrl_img[pgs_pkg::CTRL_USED_POS +: GW]    = used_ff;
        stat_img = '0;
        stat_img[pgs_pkg::STAT_ACT_POS +: GW]          = active_ff;
        stat_img[pgs_pkg::STAT_STATIC_POS +: N_GROUPS] = req_static;
        stat_img[pgs_pkg::STAT_REQ_POS +: N_GROUPS]    = i_group_request;
    end

    always_comb begin
        nxt_rdata = '0;
        if (i_rd) begin
            unique case (i_addr)
                pgs_pkg::OFF_CTRL:   nxt_rdata = ctrl_img;
                pgs_pkg::OFF_REMOTE: nxt_rdata = {{(pgs_pkg::DATA_W-SW){1'b0}}, remote_sel_ff};
                pgs_pkg::OFF_LOCAL:  nxt_rdata = {{(pgs_pkg::DATA_W-SW){1'b0}}, local_sel_ff};
                pgs_pkg::OFF_STATUS: nxt_rdata = stat_img;
                default:             nxt_rdata = '0;
            endcase
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            rdata_ff <= '0;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    // Event levels, gathered into one record for the edge detector.
    pgs_pkg::pgs_lvl_t lvl;
    logic [N_GROUPS-1:0] act_onehot;

    for (genvar g = 0; g < N_GROUPS; g++) begin : g_act
        assign act_onehot[g] = (active_ff == GW'(g));
    end

    always_comb begin
        lvl            = '0;
        lvl.req        = i_group_request;
        lvl.act        = act_onehot;
        lvl.en         = used_mask[N_GROUPS-1:1];
        lvl.remote_chg = rem_pend;
        lvl.local_chg  = loc_pend;
        lvl.force_chg  = frc_en_ff;
        lvl.fail_cfg   = fail_cfg;
        lvl.fail_force = frc_fail;
        lvl.fail_prio  = fail_prio;
    end

    // The reset image marks group one active so reset alone raises no event.
    localparam pgs_pkg::pgs_lvl_t LVL_INIT = '{
        req:        '0,
        act:        N_GROUPS'(1),
        en:         '0,
        remote_chg: 1'b0,
        local_chg:  1'b0,
        force_chg:  1'b0,
        fail_cfg:   1'b0,
        fail_force: 1'b0,
        fail_prio:  1'b0
    };

    logic [EW-1:0] ev_on;
    logic [EW-1:0] ev_off;

    pgs_edge_events #(
        .W    (EW),
        .INIT (LVL_INIT)
    ) u_events (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_lvl     (lvl),
        .o_on      (ev_on),
        .o_off     (ev_off)
    );

    assign o_events_on    = ev_on;
    assign o_events_off   = ev_off;
    assign o_rdata        = rdata_ff;
    assign o_active_group = active_ff;

endmodule : pgs_top

// ### tb/pgs_assertions.sv
// Port-level checks for the priority group selector.
`timescale 1ns/100ps
module pgs_assertions #(
    parameter int N_GROUPS = 8,
    parameter int HOLD_CYC = 50
) (
    input wire logic                       i_clk_sys,
    input wire logic                       i_rst,
    input wire logic [N_GROUPS-1:0]        i_group_request,
    input wire logic [pgs_pkg::ADDR_W-1:0] i_addr,
    input wire logic [pgs_pkg::DATA_W-1:0] i_wdata,
    input wire logic                       i_wr,
    input wire logic                       i_rd,
    input wire logic [pgs_pkg::DATA_W-1:0] o_rdata,
    input wire logic [pgs_pkg::GRP_W-1:0]  o_active_group,
    input wire pgs_pkg::pgs_lvl_t          o_events_on,
    input wire pgs_pkg::pgs_lvl_t          o_events_off
);
    logic [N_GROUPS-1:0] req_ff;
    logic                frc_ff;
    logic [2:0]          used_ff;
    logic [3:0]          rem_ff;
    logic [3:0]          loc_ff;
    wire  [N_GROUPS-1:0] rise_w   = i_group_request & ~req_ff;
    wire  [N_GROUPS-1:0] fall_w   = ~i_group_request & req_ff;
    wire                 ctrl_w   = i_wr && i_addr == pgs_pkg::OFF_CTRL;
    wire                 rem_w    = i_wr && i_addr == pgs_pkg::OFF_REMOTE;
    wire                 loc_w    = i_wr && i_addr == pgs_pkg::OFF_LOCAL;
    // Shift is four bits wide so that eight used groups leave nothing above them.
    wire  [N_GROUPS-1:0] unused_w = rise_w >> ({1'b0, used_ff} + 4'h1);

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            {req_ff, frc_ff, used_ff, rem_ff, loc_ff} <= '0;
        end else begin
            req_ff <= i_group_request;
            if (ctrl_w) {frc_ff, used_ff} <= {i_wdata[0], i_wdata[10:8]};
            if (rem_w) rem_ff <= i_wdata[3:0];
            if (loc_w) loc_ff <= i_wdata[3:0];
        end
    end

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    sequence s_act_swap;
        o_events_on.act[$past(o_active_group)] && o_events_off.act[$past(o_active_group, 2)];
    endsequence
    sequence s_cause;
        // A held static level reasserts its group, so any standing request is a cause.
        $past(i_group_request) != 0 || $past(i_wr) || $past(i_wr, 2);
    endsequence

    a_reset_home: assert property ($past(i_rst) |-> o_active_group == 3'h0)
        else $error("active group not one after reset");
    a_active_swap: assert property (!$stable(o_active_group) |=> s_act_swap)
        else $error("active change without paired events");
    a_no_self_change: assert property (!$stable(o_active_group) |-> s_cause)
        else $error("active group changed with no request");
    a_req_rise_event: assert property (rise_w != 0 |=> o_events_on.req == $past(rise_w))
        else $error("request ON event wrong");
    a_req_fall_event: assert property (fall_w != 0 |=> o_events_off.req == $past(fall_w))
        else $error("request OFF event wrong");
    a_top_group_wins: assert property (rise_w[0] && !frc_ff && !i_wr |=> o_active_group == 3'h0)
        else $error("group one request not taken");
    a_cfg_refused: assert property (unused_w != 0 && !frc_ff |-> ##[1:3] o_events_on.fail_cfg)
        else $error("unused group request not flagged");
    a_remote_on: assert property (rem_w && i_wdata[3:0] != 4'h0 && rem_ff == 4'h0
        |-> ##[1:3] o_events_on.remote_chg)
        else $error("remote change ON missing");
    a_local_off: assert property (loc_w && i_wdata[3:0] == 4'h0 && loc_ff != 4'h0
        |-> ##[1:3] o_events_off.local_chg)
        else $error("local change OFF missing");
    a_force_on: assert property (ctrl_w && i_wdata[0] && !frc_ff |-> ##[1:3] o_events_on.force_chg)
        else $error("force change ON missing");
    a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == '0)
        else $error("read data outside read cycle");
endmodule : pgs_assertions

bind pgs_top pgs_assertions #(.N_GROUPS(N_GROUPS), .HOLD_CYC(HOLD_CYC)) u_chk (
    .i_clk_sys       (i_clk_sys),
    .i_rst           (i_rst),
    .i_group_request (i_group_request),
    .i_addr          (i_addr),
    .i_wdata         (i_wdata),
    .i_wr            (i_wr),
    .i_rd            (i_rd),
    .o_rdata         (o_rdata),
    .o_active_group  (o_active_group),
    .o_events_on     (o_events_on),
    .o_events_off    (o_events_off)
);

// ### tb/pgs_req_source.sv
// Behavioural source of the group request lines: digital inputs and relay logic.
`timescale 1ns/100ps
module pgs_req_source (
    input  wire logic       i_clk_sys,
    output logic      [7:0] o_req
);
    initial o_req = 8'h00;
    task automatic drive(input logic [7:0] v);
        @(posedge i_clk_sys);
        o_req <= v;
    endtask : drive
    // One clock wide, so it stays a pulse for any static threshold above one.
    task automatic pulse(input logic [7:0] m);
        logic [7:0] base;
        base = o_req;
        drive(base | m);
        drive(base);
    endtask : pulse
    // Group two follows the inverted coil status, so a broken wire lands on group two.
    task automatic coil(input logic connected);
        drive({6'h00, ~connected, connected});
    endtask : coil
endmodule : pgs_req_source

// ### tb/pgs_top_tb.sv
// Self-checking bench for the priority group selector.
`timescale 1ns/100ps
module pgs_top_tb;
    localparam int HOLD = 2;
    logic                       clk;
    logic                       rst;
    logic [7:0]                 req;
    logic [pgs_pkg::ADDR_W-1:0] addr;
    logic [31:0]                wdata;
    logic                       wr;
    logic                       rd;
    logic [31:0]                rdata;
    logic [2:0]                 act;
    pgs_pkg::pgs_lvl_t          ev_on;
    pgs_pkg::pgs_lvl_t          ev_off;
    pgs_pkg::pgs_lvl_t          seen_on;
    pgs_pkg::pgs_lvl_t          seen_off;
    logic [31:0]                d;
    int                         num_errors;
    int                         n_compared;

    pgs_req_source u_src (.i_clk_sys(clk), .o_req(req));
    pgs_top #(.HOLD_CYC(HOLD)) u_dut (
        .i_clk_sys       (clk),
        .i_rst           (rst),
        .i_group_request (req),
        .i_addr          (addr),
        .i_wdata         (wdata),
        .i_wr            (wr),
        .i_rd            (rd),
        .o_rdata         (rdata),
        .o_active_group  (act),
        .o_events_on     (ev_on),
        .o_events_off    (ev_off)
    );

    always #10 clk = ~clk;
    // Event pulses are gathered mid-cycle so no edge race can hide one.
    always @(negedge clk) begin
        seen_on = seen_on | ev_on;
        seen_off = seen_off | ev_off;
    end

    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk
    task automatic run(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : run
    task automatic clr;
        seen_on = '0;
        seen_off = '0;
    endtask : clr
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [3:0] a);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg
    task automatic wrap_up;
        if (num_errors == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : wrap_up

    task automatic t_reset;
        chk("active", act, 0);
        rd_reg(pgs_pkg::OFF_STATUS);
        chk("status", d, 0);
        clr();
        wr_reg(pgs_pkg::OFF_CTRL, 32'h0000_0700);
        run(3);
        chk("enable on", seen_on.en, 7'h7f);
        rd_reg(pgs_pkg::OFF_CTRL);
        chk("ctrl", d, 32'h0000_0700);
        rd_reg(4'hf);
        chk("unmapped", d, 0);
    endtask : t_reset
    task automatic t_pulses;
        logic [2:0] p;
        u_src.coil(1'b1);
        run(HOLD + 3);
        chk("coil on", act, 0);
        u_src.coil(1'b0);
        run(HOLD + 3);
        chk("coil off", act, 1);
        u_src.drive(8'h00);
        run(2);
        for (int k = 0; k < 8; k++) begin
            p = act;
            clr();
            u_src.pulse(8'h01 << k);
            run(3);
            chk("pulse", act, k);
            chk("act ev", {seen_on.act, seen_off.act}, {8'h01 << k, 8'h01 << p});
            chk("req ev", {seen_on.req, seen_off.req}, {8'h01 << k, 8'h01 << k});
        end
        u_src.pulse(8'h14);
        run(3);
        chk("prio", act, 2);
        u_src.pulse(8'hc0);
        run(3);
        chk("prio low", act, 6);
        run(20);
        chk("stays", act, 6);
    endtask : t_pulses
    task automatic t_static;
        int l;
        for (int h = 0; h < 8; h++) begin
            u_src.drive(8'h01 << h);
            run(HOLD + 3);
            chk("static", act, h);
            rd_reg(pgs_pkg::OFF_STATUS);
            chk("stat", d, {8'h00, 8'h01 << h, 8'h01 << h, 8'(h)});
            l = (h == 7) ? 6 : 7;
            clr();
            u_src.pulse(8'h01 << l);
            run(3);
            // A lower pulse leaves a static group selected; group eight yields to the group seven pulse, then takes the selection back.
            chk("lower", act, h);
            chk("lower ev", seen_on.act[l], h == 7);
            if (h < 7) chk("prio fail", {seen_on.fail_prio, seen_off.fail_prio}, 2'b11);
            if (h > 0) begin
                u_src.drive((8'h01 << h) | (8'h01 << (h - 1)));
                run(HOLD + 3);
                chk("higher", act, h - 1);
            end
            u_src.drive(8'h00);
            run(2);
        end
    endtask : t_static
    task automatic t_config;
        clr();
        wr_reg(pgs_pkg::OFF_CTRL, 32'h0000_0200);
        u_src.pulse(8'h10);
        run(3);
        chk("disable", seen_off.en, 7'h7c);
        chk("cfg fail", {seen_on.fail_cfg, seen_off.fail_cfg, act}, {2'b11, 3'h6});
        wr_reg(pgs_pkg::OFF_CTRL, 32'h0000_0700);
        clr();
        wr_reg(pgs_pkg::OFF_REMOTE, 32'h4);
        run(3);
        chk("remote", {seen_on.remote_chg, act}, {1'b1, 3'h3});
        rd_reg(pgs_pkg::OFF_REMOTE);
        chk("remote reg", d, 4);
        wr_reg(pgs_pkg::OFF_REMOTE, 32'h0);
        run(3);
        chk("remote off", seen_off.remote_chg, 1);
        u_src.drive(8'h02);
        run(HOLD + 3);
        wr_reg(pgs_pkg::OFF_REMOTE, 32'h5);
        run(3);
        chk("remote lost", act, 1);
        u_src.drive(8'h00);
        wr_reg(pgs_pkg::OFF_REMOTE, 32'h0);
        clr();
        wr_reg(pgs_pkg::OFF_LOCAL, 32'h6);
        run(3);
        chk("local", {seen_on.local_chg, act}, {1'b1, 3'h5});
        wr_reg(pgs_pkg::OFF_LOCAL, 32'h0);
        run(3);
        chk("local off", seen_off.local_chg, 1);
    endtask : t_config
    task automatic t_force;
        clr();
        wr_reg(pgs_pkg::OFF_CTRL, 32'h0000_0771);
        run(4);
        chk("forced", {seen_on.force_chg, act}, {1'b1, 3'h6});
        u_src.pulse(8'h01);
        run(3);
        chk("override", act, 6);
        wr_reg(pgs_pkg::OFF_CTRL, 32'h0000_0271);
        run(4);
        chk("force fail", {seen_on.fail_force, act}, {1'b1, 3'h6});
        wr_reg(pgs_pkg::OFF_CTRL, 32'h0000_0700);
        run(4);
        chk("force off", {seen_off.force_chg, seen_off.fail_force}, 2'b11);
        u_src.pulse(8'h01);
        run(3);
        rd_reg(pgs_pkg::OFF_STATUS);
        chk("status", d, 0);
    endtask : t_force

    initial begin
        clk = 1'b0;
        rst = 1'b1;
        addr = '0;
        wdata = '0;
        wr = 1'b0;
        rd = 1'b0;
        num_errors = 0;
        n_compared = 0;
        clr();
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_pulses();
        t_static();
        t_config();
        t_force();
        wrap_up();
    end
    initial begin
        repeat (5000) @(posedge clk);
        num_errors++;
        wrap_up();
    end
endmodule : pgs_top_tb
